// ==== hw/lram_cfg.svh ====
`ifndef LRAM_CFG_SVH
`define LRAM_CFG_SVH

// Register offsets (byte addresses)
`define LRAM_OFS_CFG 12'h000
`define LRAM_OFS_STAT 12'h004

// Configuration register fields
`define LRAM_F_WA 0
`define LRAM_F_WB 3
`define LRAM_F_MODE 6
`define LRAM_F_OREG_A 8
`define LRAM_F_OREG_B 9
`define LRAM_F_B8_A 10
`define LRAM_F_B8_B 11
`define LRAM_CFG_W 12
`define LRAM_CFG_RST 12'h000

// Status register fields
`define LRAM_F_ERR 0
`define LRAM_F_EMPTY 1
`define LRAM_F_FULL 2
`define LRAM_F_LEVEL 15

// Storage geometry and FIFO capacity in nine-bit lanes
`define LRAM_WORDS 4096
`define LRAM_WCODE_MAX 3'h4
`define LRAM_FIFO_LANES 18'h10000

`endif

// ==== hw/lram_pkg.sv ====
package lram_pkg;

	typedef enum logic [1:0] {
		LRAM_TDP,
		LRAM_SDP,
		LRAM_SP,
		LRAM_FIFO
	} lram_mode_e;

	typedef logic [2:0] lram_wcode_t;

endpackage : lram_pkg

// ==== hw/lram_top.sv ====
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// [R1] Storage holds 589,824 bits including parity bits
// [R2] One organisation: true dual, simple dual, single, FIFO
// [R3] No preload; contents undefined until written
// [R4] All inputs captured in registers on clock
// [R5] Output register optional per port, bypassable
// [R6] Widths 9, 18, 36, 72, 144 bits
// [R7] 144-bit width rejected in true dual-port mode
// [R8] Mixed widths allowed; 144 pairs only with 144
// [R9] Single write select; no read enable
// [R10] Lane stored when write select and mask high
// [R11] Mask bit i gates bits 9i+8 to 9i
// [R12] Wide mode: two mask groups form 16 masks
// [R13] Any mask combination; other lanes unchanged
// [R14] Eight-bit modes use 8-bit lanes
// [R15] Input registers share one clock
// [R16] User supplies clock, enable, select, clear per port; both ports here share the single clock i_clk
// [R17] Each port has 72 data in and out
// [R18] User supplies 16-bit address, 8-bit mask per port
// [R19] Port registers use own enable and clear
// [R20] Simple dual: A writes, B reads
// [R21] Masks ignored on reads; full width returned
// [R22] Clear resets port registers, not array contents
`include "lram_cfg.svh"
module lram_top
	import lram_pkg::*;
#(
	parameter int WORDS = `LRAM_WORDS,
	parameter int PW = 72
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clr_a,
	input wire logic i_clr_b,
	input wire logic i_clken_a,
	input wire logic i_clken_b,
	input wire logic i_wren_a,
	input wire logic i_wren_b,
	input wire logic [15:0] i_addr_a,
	input wire logic [15:0] i_addr_b,
	input wire logic [PW-1:0] i_wdata_a,
	input wire logic [PW-1:0] i_wdata_b,
	input wire logic [7:0] i_mask_a,
	input wire logic [7:0] i_mask_b,
	output logic [PW-1:0] o_rdata_a,
	output logic [PW-1:0] o_rdata_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	function automatic logic [143:0] lram_pack(input logic [143:0] d, input logic b8);
		logic [143:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[9*i +: 9] = b8 ? {1'b0, d[8*i +: 8]} : d[9*i +: 9]; // R14
		end
		return r;
	endfunction : lram_pack

	function automatic logic [143:0] lram_unpack(input logic [143:0] rb, input logic [3:0] off,
			input logic [4:0] nl, input logic b8);
		logic [143:0] r;
		logic [8:0] lane;
		logic [3:0] idx;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			idx = 4'(off + 4'(i));
			lane = (5'(i) < nl) ? rb[9*idx +: 9] : 9'h000;
			if (b8) begin
				r[8*i +: 8] = lane[7:0];
			end else begin
				r[9*i +: 9] = lane;
			end
		end
		return r;
	endfunction : lram_unpack

	// Configuration and APB slave
	logic [`LRAM_CFG_W-1:0] cfg_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [16:0] wptr_q;
	logic [16:0] rptr_q;
	lram_wcode_t wcode [2];
	logic [1:0] oreg;
	logic [1:0] b8;
	lram_mode_e mode;
	assign wcode[0] = cfg_q[`LRAM_F_WA +: 3];
	assign wcode[1] = cfg_q[`LRAM_F_WB +: 3];
	assign mode = lram_mode_e'(cfg_q[`LRAM_F_MODE +: 2]); // R2
	assign oreg = {cfg_q[`LRAM_F_OREG_B], cfg_q[`LRAM_F_OREG_A]};
	assign b8 = {cfg_q[`LRAM_F_B8_B], cfg_q[`LRAM_F_B8_A]};
	wire wide = (wcode[0] == `LRAM_WCODE_MAX);
	wire any_wide = wide | (wcode[1] == `LRAM_WCODE_MAX);
	wire wide_mode = (mode == LRAM_SDP) | (mode == LRAM_FIFO);
	wire code_bad = (wcode[0] > `LRAM_WCODE_MAX) | (wcode[1] > `LRAM_WCODE_MAX);
	wire wide_bad = any_wide & ~(wide_mode & wide & (wcode[1] == `LRAM_WCODE_MAX)); // R7 R8
	wire cfg_err = code_bad | wide_bad;
	wire [16:0] level = 17'(wptr_q - rptr_q);
	wire [4:0] nl [2];
	wire fifo_room = (18'(level) + 18'(nl[0])) <= `LRAM_FIFO_LANES;
	wire fifo_avail = level >= 17'(nl[1]);
	wire fifo = (mode == LRAM_FIFO);
	wire apb_setup = i_psel & ~i_penable;
	wire apb_done = i_psel & i_penable & pready_q;
	wire hit_cfg = (i_paddr == `LRAM_OFS_CFG);
	wire hit_stat = (i_paddr == `LRAM_OFS_STAT);
	wire [31:0] stat_word = {level, 12'h000, ~fifo_room, ~fifo_avail, cfg_err};
	wire [31:0] rd_word = hit_cfg ? {20'h00000, cfg_q} : (hit_stat ? stat_word : 32'h0000_0000);
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cfg_q <= `LRAM_CFG_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_setup;
			prdata_q <= apb_setup ? rd_word : 32'h0000_0000;
			pslverr_q <= apb_setup & ~(hit_cfg | hit_stat);
			if (apb_done & i_pwrite & hit_cfg) begin
				cfg_q <= i_pwdata[`LRAM_CFG_W-1:0];
			end
		end
	end
	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	// Port inputs gathered per index: 0 is A, 1 is B
	wire [1:0] clr_in = {i_clr_b, i_clr_a};
	wire [1:0] clken_in = {i_clken_b, i_clken_a};
	wire [1:0] wren_in = {i_wren_b, i_wren_a};
	wire [15:0] addr_in [2];
	wire [PW-1:0] wd_in [2];
	wire [7:0] mk_in [2];
	assign addr_in[0] = i_addr_a;
	assign addr_in[1] = i_addr_b;
	assign wd_in[0] = i_wdata_a;
	assign wd_in[1] = i_wdata_b;
	assign mk_in[0] = i_mask_a;
	assign mk_in[1] = i_mask_b;
	wire [1:0] acc_r;
	wire [1:0] wr_r;
	wire [15:0] ad_r [2];
	wire [PW-1:0] wd_r [2];
	wire [7:0] mk_r [2];
	wire [PW-1:0] out_r [2];
	wire [15:0] ls [2];
	wire [143:0] rb [2];
	wire [143:0] rdu [2];
	wire [PW-1:0] rsel [2];
	wire [1:0] rtrig;
	wire [1:0] rd_now;
	wire [1:0] wr_now;
	wire [143:0] pk [2];
	wire [15:0] mfull [2];
	wire [15:0] we_lane_a;
	wire [15:0] we_lane_b;

	assign ls[0] = fifo ? wptr_q[15:0] : 16'(ad_r[0] << wcode[0]);
	assign ls[1] = fifo ? rptr_q[15:0] : 16'(ad_r[1] << wcode[1]);
	assign wr_now[0] = acc_r[0] & wr_r[0] & ~cfg_err & (~fifo | fifo_room); // R10 R20
	assign wr_now[1] = acc_r[1] & wr_r[1] & ~cfg_err & (mode == LRAM_TDP); // R20
	assign rd_now[0] = acc_r[0] & ~wr_r[0] & ~cfg_err & ((mode == LRAM_TDP) | (mode == LRAM_SP)); // R9
	assign rd_now[1] = acc_r[1] & ~wr_r[1] & ~cfg_err & ((mode == LRAM_TDP) | (mode == LRAM_SDP) | (fifo & fifo_avail));
	// Wide write word joins both data groups; masks join likewise
	assign pk[0] = lram_pack(wide ? (b8[0] ? {16'h0000, wd_r[1][63:0], wd_r[0][63:0]} : {wd_r[1], wd_r[0]})
			: {72'h0, wd_r[0]}, b8[0]); // R12 R14
	assign pk[1] = lram_pack({72'h0, wd_r[1]}, b8[1]);
	assign mfull[0] = wide ? {mk_r[1], mk_r[0]} : {8'h00, mk_r[0]}; // R12
	assign mfull[1] = {8'h00, mk_r[1]};
	// In wide mode both outputs carry halves of the port B read
	assign rsel[0] = wide ? (b8[1] ? {8'h00, rdu[1][63:0]} : rdu[1][71:0])
			: (b8[0] ? {8'h00, rdu[0][63:0]} : rdu[0][71:0]);
	assign rsel[1] = wide ? (b8[1] ? {8'h00, rdu[1][127:64]} : rdu[1][143:72])
			: (b8[1] ? {8'h00, rdu[1][63:0]} : rdu[1][71:0]);
	assign rtrig[0] = wide ? rd_now[1] : rd_now[0];
	assign rtrig[1] = rd_now[1];

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic acc_q;
		logic wr_q;
		logic [15:0] ad_q;
		logic [PW-1:0] wd_q;
		logic [7:0] mk_q;
		logic [PW-1:0] stg_q;
		logic stv_q;
		logic [PW-1:0] out_q;
		assign nl[p] = 5'(5'h01 << wcode[p]); // R6
		assign rdu[p] = lram_unpack(rb[p], ls[p][3:0], nl[p], b8[p]); // R21
		always_ff @(posedge i_clk or posedge clr_in[p]) begin // R19 R22
			if (clr_in[p]) begin
				acc_q <= 1'b0;
				wr_q <= 1'b0;
				ad_q <= 16'h0000;
				wd_q <= '0;
				mk_q <= 8'h00;
				stg_q <= '0;
				stv_q <= 1'b0;
				out_q <= '0;
			end else if (i_reset) begin
				acc_q <= 1'b0;
				wr_q <= 1'b0;
				ad_q <= 16'h0000;
				wd_q <= '0;
				mk_q <= 8'h00;
				stg_q <= '0;
				stv_q <= 1'b0;
				out_q <= '0;
			end else begin
				acc_q <= clken_in[p]; // R4 R15 R16
				if (clken_in[p]) begin
					wr_q <= wren_in[p];
					ad_q <= addr_in[p];
					wd_q <= wd_in[p];
					mk_q <= mk_in[p];
				end
				stv_q <= rtrig[p];
				if (rtrig[p]) begin
					stg_q <= rsel[p];
				end
				if (oreg[p] ? stv_q : rtrig[p]) begin
					out_q <= oreg[p] ? stg_q : rsel[p]; // R5
				end
			end
		end
		assign acc_r[p] = acc_q;
		assign wr_r[p] = wr_q;
		assign ad_r[p] = ad_q;
		assign wd_r[p] = wd_q;
		assign mk_r[p] = mk_q;
		assign out_r[p] = out_q;
	end
	assign o_rdata_a = out_r[0]; // R17
	assign o_rdata_b = out_r[1];

	// Sixteen nine-bit lane banks of WORDS entries, no initial contents
	for (genvar k = 0; k < 16; k++) begin : g_bank
		logic [8:0] mem [WORDS]; // R1 R3
		wire [3:0] rel_a = 4'(4'(k) - ls[0][3:0]);
		wire [3:0] rel_b = 4'(4'(k) - ls[1][3:0]);
		wire [11:0] word_a = ls[0][15:4];
		wire [11:0] word_b = ls[1][15:4];
		assign we_lane_a[k] = wr_now[0] & (5'(rel_a) < nl[0]) & mfull[0][rel_a]; // R10 R11 R13
		assign we_lane_b[k] = wr_now[1] & (5'(rel_b) < nl[1]) & mfull[1][rel_b];
		always_ff @(posedge i_clk) begin
			if (we_lane_a[k]) begin
				mem[word_a] <= pk[0][9*rel_a +: 9];
			end
			if (we_lane_b[k]) begin
				mem[word_b] <= pk[1][9*rel_b +: 9];
			end
		end
		assign rb[0][9*k +: 9] = mem[word_a];
		assign rb[1][9*k +: 9] = mem[word_b];
	end

	// FIFO pointers in lane units
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wptr_q <= 17'h00000;
			rptr_q <= 17'h00000;
		end else begin
			if (fifo & wr_now[0]) begin
				wptr_q <= 17'(wptr_q + 17'(nl[0]));
			end
			if (fifo & rd_now[1]) begin
				rptr_q <= 17'(rptr_q + 17'(nl[1]));
			end
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	property p_r2_sp_b_idle;
		(mode == LRAM_SP) |-> (we_lane_b == 16'h0000) && !rd_now[1];
	endproperty
	a_r2_sp_b_idle: assert property (p_r2_sp_b_idle) else $error("port B active in single-port mode"); // R2
	property p_r4_capture;
		(i_clken_a && !i_clr_a) ##1 !i_clr_a |-> acc_r[0] && (wr_r[0] == $past(i_wren_a));
	endproperty
	a_r4_capture: assert property (p_r4_capture) else $error("port A inputs not captured"); // R4
	property p_r5_bypass;
		(rtrig[0] && !oreg[0] && !i_clr_a) ##1 !i_clr_a |-> o_rdata_a == $past(rsel[0]);
	endproperty
	a_r5_bypass: assert property (p_r5_bypass) else $error("bypassed read data late or wrong"); // R5
	property p_r5_oreg;
		(rtrig[0] && oreg[0] && !i_clr_a) ##1 (!i_clr_a && $stable(cfg_q)) ##1 !i_clr_a
			|-> o_rdata_a == $past(rsel[0], 2);
	endproperty
	a_r5_oreg: assert property (p_r5_oreg) else $error("registered read data wrong"); // R5
	property p_r7_tdp_wide;
		(mode == LRAM_TDP) && (wcode[0] == 3'h4 || wcode[1] == 3'h4) |-> cfg_err && (we_lane_a == 16'h0000);
	endproperty
	a_r7_tdp_wide: assert property (p_r7_tdp_wide) else $error("wide mode accepted in true dual-port"); // R7
	property p_r8_pair;
		(wcode[0] == 3'h4) != (wcode[1] == 3'h4) |-> cfg_err && !rd_now[1];
	endproperty
	a_r8_pair: assert property (p_r8_pair) else $error("144-bit paired with narrower width"); // R8
	property p_r9_select;
		acc_r[0] && wr_r[0] |-> !rd_now[0];
	endproperty
	a_r9_select: assert property (p_r9_select) else $error("write select also read"); // R9
	property p_r10_mask_off;
		acc_r[0] && wr_r[0] && (mk_r[0] == 8'h00) && !wide |-> we_lane_a == 16'h0000;
	endproperty
	a_r10_mask_off: assert property (p_r10_mask_off) else $error("masked lane written"); // R10
	property p_r11_lanes;
		wr_now[0] && !wide && (wcode[0] == 3'h3) && !fifo |-> we_lane_a == 16'({8'h00, mk_r[0]} << ls[0][3:0]);
	endproperty
	a_r11_lanes: assert property (p_r11_lanes) else $error("lane enables do not follow masks"); // R11
	property p_r12_wide_mask;
		wr_now[0] && wide |-> we_lane_a == {mk_r[1], mk_r[0]};
	endproperty
	a_r12_wide_mask: assert property (p_r12_wide_mask) else $error("wide masks not joined"); // R12
	property p_r20_sdp_b;
		(mode == LRAM_SDP) |-> (we_lane_b == 16'h0000) && !rd_now[0];
	endproperty
	a_r20_sdp_b: assert property (p_r20_sdp_b) else $error("simple dual-port roles broken"); // R20
	property p_r21_read_nowrite;
		rd_now[0] |-> we_lane_a == 16'h0000;
	endproperty
	a_r21_read_nowrite: assert property (p_r21_read_nowrite) else $error("read cycle wrote lanes"); // R21
	property p_r22_clear;
		i_clr_a ##1 i_clr_a |-> (o_rdata_a == '0) && !acc_r[0];
	endproperty
	a_r22_clear: assert property (p_r22_clear) else $error("clear left port A state"); // R22
	c_wide_write: cover property (wr_now[0] && wide);
	c_tdp_both_write: cover property (wr_now[0] && wr_now[1]);
	c_fifo_read: cover property (fifo && rd_now[1] ##3 o_rdata_b != '0);
endmodule : lram_top

// ==== tb/lram_user.sv ====
`timescale 1ns/1ps
module lram_user (
	input wire logic i_clk,
	output logic o_clken,
	output logic o_wren,
	output logic [15:0] o_addr,
	output logic [71:0] o_wdata,
	output logic [7:0] o_mask
);
	initial begin
		o_clken = 1'b0;
		o_wren = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 72'h0;
		o_mask = 8'hff;
	end

	// One request per call; on release enable and select drop low, address, data and mask show the inverse so stale values never pass
	task automatic req(input logic en, input logic w, input logic [15:0] a, input logic [71:0] d,
			input logic [7:0] m);
		@(posedge i_clk);
		o_clken <= en;
		o_wren <= w;
		o_addr <= a;
		o_wdata <= d;
		o_mask <= m;
		@(posedge i_clk);
		o_clken <= 1'b0;
		o_wren <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		o_mask <= ~m;
	endtask : req
endmodule : lram_user

// ==== tb/lram_tb_top.sv ====
`timescale 1ns/1ps
module lram_tb_top;
	import lram_pkg::*;
	logic i_clk, i_reset, clr_a, clr_b, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ca, cb, wa, wb;
	logic [15:0] aa, ab;
	logic [71:0] da, db, qa, qb;
	logic [7:0] ma, mb;
	logic [143:0] p, q, e;
	logic [31:0] bad [3] = '{32'h004, 32'h044, 32'h005};
	int n_errors = 0;
	int n_tests = 0;

	lram_user u_pa (.i_clk(i_clk), .o_clken(ca), .o_wren(wa), .o_addr(aa), .o_wdata(da), .o_mask(ma));
	lram_user u_pb (.i_clk(i_clk), .o_clken(cb), .o_wren(wb), .o_addr(ab), .o_wdata(db), .o_mask(mb));
	lram_top uut (.i_clk(i_clk), .i_reset(i_reset), .i_clr_a(clr_a), .i_clr_b(clr_b), .i_clken_a(ca),
		.i_clken_b(cb), .i_wren_a(wa), .i_wren_b(wb), .i_addr_a(aa), .i_addr_b(ab), .i_wdata_a(da),
		.i_wdata_b(db), .i_mask_a(ma), .i_mask_b(mb), .o_rdata_a(qa), .o_rdata_b(qb), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [143:0] seen, input logic [143:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cfg(input logic [31:0] v);
		apb(1'b1, 12'h000, v);
		apb(1'b0, 12'h000, 32'h0);
		chk("cfg", rd, v);
	endtask : cfg

	// Port B read; wide joins both outputs as in the 144-bit mode
	task automatic rdb(input logic [15:0] a, input int lat, input logic wide, input logic [143:0] exp,
			input string nm);
		u_pb.req(1'b1, 1'b0, a, 72'h0, 8'h00);
		repeat (lat - 1) @(posedge i_clk);
		#1;
		chk(nm, wide ? {qb, qa} : {72'h0, qb}, exp);
	endtask : rdb

	function automatic logic [143:0] mrg(input logic [143:0] o, input logic [143:0] n, input logic [15:0] m);
		mrg = o;
		for (int i = 0; i < 16; i++) begin
			if (m[i]) mrg[9*i+:9] = n[9*i+:9];
		end
	endfunction : mrg

	initial begin
		#500000;
		n_errors++;
		results();
	end

	initial begin
		i_reset = 1'b1;
		clr_a = 1'b0;
		clr_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk("cfg_reset", rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk("err_reset", rd[0], 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped", {er, rd}, {1'b1, 32'h0});
		foreach (bad[i]) begin
			apb(1'b1, 12'h000, bad[i]);
			apb(1'b0, 12'h004, 32'h0);
			chk("cfg_err", rd[0], 1'b1);
		end
		// 72-bit writes on A, 9-bit reads on B of the same lanes
		cfg(32'h003);
		p = {72'h0, 72'h96_8765_4321_0fed_cba9};
		q = {72'h0, 72'h3c_a5f0_1e2d_4b69_785a};
		u_pa.req(1'b1, 1'b1, 16'h0002, p[71:0], 8'hff);
		u_pa.req(1'b1, 1'b1, 16'h0002, q[71:0], 8'ha5);
		e = mrg(p, q, 16'h00a5);
		for (int i = 0; i < 8; i++) begin
			rdb(16'(16 + i), 2, 1'b0, e[9*i+:9], "lane");
		end
		u_pa.req(1'b1, 1'b0, 16'h0002, 72'h0, 8'h00);
		@(posedge i_clk);
		#1;
		chk("read_a", qa, e[71:0]);
		// Eight-bit lanes with the B output register on
		cfg(32'h0e09);
		u_pa.req(1'b1, 1'b1, 16'h0007, 72'h1234, 8'h03);
		u_pa.req(1'b1, 1'b1, 16'h0007, 72'hbeef, 8'h01);
		u_pb.req(1'b1, 1'b0, 16'h0007, 72'h0, 8'h00);
		@(posedge i_clk);
		#1;
		chk("oreg_hold", qb, e[63+:9]);
		@(posedge i_clk);
		#1;
		chk("byte_lane", qb, 72'h12ef);
		@(posedge i_clk);
		clr_b <= 1'b1;
		#1;
		chk("clr_b", qb, 72'h0);
		chk("clr_keep_a", qa, e[71:0]);
		@(posedge i_clk);
		clr_b <= 1'b0;
		rdb(16'h0007, 3, 1'b0, 144'h12ef, "after_clr");
		// Clear on A for two edges drops its output
		@(posedge i_clk);
		clr_a <= 1'b1;
		repeat (2) @(posedge i_clk);
		clr_a <= 1'b0;
		#1;
		chk("clr_a", qa, 72'h0);
		// Single-port: masked A write and all B requests change nothing
		cfg(32'h083);
		u_pa.req(1'b1, 1'b1, 16'h0002, ~e[71:0], 8'h00);
		u_pb.req(1'b1, 1'b1, 16'h0010, 72'h1ff, 8'hff);
		rdb(16'h0011, 2, 1'b0, 144'h12ef, "sp_b_read");
		u_pa.req(1'b1, 1'b0, 16'h0002, 72'h0, 8'hff);
		@(posedge i_clk);
		#1;
		chk("sp_read", qa, e[71:0]);
		// 144-bit simple dual-port: A writes both halves, B reads
		// B must load its half, so its enable is high; A output register on
		cfg(32'h164);
		p = {8{18'h2b3c5}};
		q = {8{18'h1d4a6}};
		fork
			u_pa.req(1'b1, 1'b1, 16'h0005, p[71:0], 8'hff);
			u_pb.req(1'b1, 1'b1, 16'h0005, p[143:72], 8'hff);
		join
		fork
			u_pa.req(1'b1, 1'b1, 16'h0005, q[71:0], 8'h81);
			u_pb.req(1'b1, 1'b1, 16'h0005, q[143:72], 8'h18);
		join
		rdb(16'h0005, 3, 1'b1, mrg(p, q, 16'h1881), "wide");
		// FIFO of nine-bit lanes: one lane in, one out, then an underrun
		cfg(32'h0c0);
		apb(1'b0, 12'h004, 32'h0);
		chk("fifo_empty", rd, 32'h0000_0002);
		u_pa.req(1'b1, 1'b1, 16'h1234, 72'h0a5, 8'hff);
		apb(1'b0, 12'h004, 32'h0);
		chk("fifo_level", rd, 32'h0000_8000);
		rdb(16'h0000, 2, 1'b0, 144'h0a5, "fifo_read");
		rdb(16'h0000, 2, 1'b0, 144'h0a5, "fifo_underrun");
		results();
	end
endmodule : lram_tb_top
